//--- pkg/ovc_pkg.sv
// Function
// RL1: Right mixer attenuation bits 3 and 2: DAC inputs, 1 means -6dB.
// RL2: Right mixer attenuation bits 1 and 0: bypass inputs, 1 = -6dB, reset 0.
// RL3: With zero-cross gating on, a gain change waits for a zero crossing.
// RL4: With timeout enabled, a pending change applies after a long wait.
// RL5: Written gain codes are staged only; active gain moves on commit.
// RL6: Commit bit 7 in either headphone register updates both sides together. Code commits both at once; a gated side moves at its own crossing or timeout.
// RL7: Headphone bit 8 silences its side; resets unmuted.
// RL8: Headphone bit 6 enables zero-cross gating for its side; resets off.
// RL9: Gain code 0 is -57dB, 1dB per step, 57 is 0dB, 63 is +6dB.
// RL10: Both headphone gain codes reset to 10_1101.
// RL11: Each output has its own gating and independent volume and mute.
// RL12: Commit bit is a write-one strobe, reads 0, writing 0 does nothing.
package ovc_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned ZERO_GATE_TIMEOUT_MS = 10;
    localparam int unsigned ZERO_GATE_TIMEOUT_CYCLES =
        (CLK_HZ / 1000) * ZERO_GATE_TIMEOUT_MS;

    localparam int unsigned ADR_W = 10;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RSPK_ATTEN = 8'h37;
    localparam logic [7:0] IDX_PHONES_LEFT = 8'h39;
    localparam logic [7:0] IDX_PHONES_RIGHT = 8'h3A;
    localparam logic [7:0] IDX_TIMEOUT_CTRL = 8'h40;
    localparam logic [7:0] IDX_GAIN_STATUS = 8'h41;

    localparam int unsigned SILENCE_BIT = 8;
    localparam int unsigned COMMIT_BIT = 7;
    localparam int unsigned ZGATE_BIT = 6;
    localparam int unsigned GAIN_MSB = 5;
    localparam int unsigned ATTEN_MSB = 3;
    localparam int unsigned TIMEOUT_EN_BIT = 0;
    localparam int unsigned STAT_RIGHT_LSB = 8;
    localparam int unsigned STAT_LEFT_PEND_BIT = 16;
    localparam int unsigned STAT_RIGHT_PEND_BIT = 17;
    localparam int unsigned SIDES = 2;
    localparam int unsigned SIDE_LEFT = 0;
    localparam int unsigned SIDE_RIGHT = 1;

    typedef logic [GAIN_MSB:0] gain_code_t;

    localparam gain_code_t GAIN_CODE_RESET = 6'h2D;

    typedef struct packed {
        logic left_dac_to_rspk_atten;
        logic right_dac_to_rspk_atten;
        logic left_bypass_to_rspk_atten;
        logic right_bypass_to_rspk_atten;
    } rspk_atten_t;

    localparam rspk_atten_t RSPK_ATTEN_RESET = 4'h0;

    typedef struct packed {
        logic silence;
        logic zero_gate_en;
        gain_code_t gain_code;
    } phones_setting_t;

    localparam phones_setting_t PHONES_RESET = {1'b0, 1'b0, GAIN_CODE_RESET};

    typedef struct packed {
        logic silence;
        logic pending;
        gain_code_t active_gain;
    } phones_output_t;
endpackage : ovc_pkg

//--- src/zero_gate.sv
`timescale 1ns/1ns
`default_nettype none
module zero_gate #(
    parameter int unsigned TIMEOUT_CYCLES = ovc_pkg::ZERO_GATE_TIMEOUT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic commit_i,
    input wire ovc_pkg::gain_code_t staged_i,
    input wire logic gate_en_i,
    input wire logic timeout_en_i,
    input wire logic sign_i,
    output logic pending_o,
    output ovc_pkg::gain_code_t active_o
);
    import ovc_pkg::*;

    localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CW-1:0] LAST_COUNT = CW'(TIMEOUT_CYCLES - 1);
    localparam logic [CW-1:0] COUNT_ONE = CW'(1);

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic sign_prev;
        logic pending;
        gain_code_t target;
        gain_code_t active;
        logic [CW-1:0] count;
    } zg_state_t;

    zg_state_t state_ff;
    zg_state_t nxt_state;
    logic crossing;
    logic timed_out;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.sync_a = sign_i;
        nxt_state.sync_b = state_ff.sync_a;
        nxt_state.sign_prev = state_ff.sync_b;
        // Sign flip of the output signal marks a zero crossing
        crossing = state_ff.sync_b ^ state_ff.sign_prev; // RL3
        timed_out = timeout_en_i && (state_ff.count == LAST_COUNT); // RL4
        if (state_ff.pending)
        begin
            nxt_state.count = state_ff.count + COUNT_ONE;
            // Dropping the gate mid-wait must not strand the change
            if (crossing || timed_out || !gate_en_i) // RL3 RL4
            begin
                nxt_state.active = state_ff.target;
                nxt_state.pending = 1'b0;
            end
        end
        // A new commit outranks a crossing in the same cycle
        if (commit_i)
        begin
            nxt_state.count = '0;
            if (gate_en_i) // RL3 RL11
            begin
                nxt_state.target = staged_i;
                nxt_state.pending = 1'b1;
            end
            else
            begin
                nxt_state.active = staged_i; // RL5
                nxt_state.pending = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= '0;
            // Synchroniser runs on so release sees no false crossing
            state_ff.sync_a <= nxt_state.sync_a;
            state_ff.sync_b <= nxt_state.sync_b;
            state_ff.sign_prev <= nxt_state.sign_prev;
            state_ff.target <= GAIN_CODE_RESET;
            state_ff.active <= GAIN_CODE_RESET; // RL10
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign pending_o = state_ff.pending;
    assign active_o = state_ff.active;
endmodule : zero_gate
`default_nettype wire

//--- src/output_volume_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
module output_volume_control_regs #(
    parameter int unsigned TIMEOUT_CYCLES = ovc_pkg::ZERO_GATE_TIMEOUT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ovc_pkg::ADR_W-1:0] adr_i,
    input wire logic [ovc_pkg::DATA_W-1:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [ovc_pkg::DATA_W-1:0] dat_o,
    output logic ack_o,
    input wire logic left_sign_i,
    input wire logic right_sign_i,
    output ovc_pkg::rspk_atten_t rspk_atten_o,
    output ovc_pkg::phones_output_t phones_left_o,
    output ovc_pkg::phones_output_t phones_right_o
);
    import ovc_pkg::*;

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
        rspk_atten_t atten;
        phones_setting_t left;
        phones_setting_t right;
        logic timeout_en;
        logic commit;
    } regs_t;

    regs_t state_ff;
    regs_t nxt_state;
    logic [7:0] idx;
    logic access;
    logic wr;
    gain_code_t active [SIDES];
    logic pending [SIDES];
    phones_setting_t cfg [SIDES];
    logic sign_in [SIDES];

    assign idx = adr_i[ADR_W-1:IDX_LSB];
    // One access per cycle; ack drops the cycle after it rose
    assign access = cyc_i && stb_i && !state_ff.ack;
    assign wr = access && we_i;

    function automatic phones_setting_t write_phones(
        input phones_setting_t cur,
        input logic [DATA_W-1:0] d,
        input logic [3:0] sel
    );
        phones_setting_t r;
        r = cur;
        if (sel[0])
        begin
            r.zero_gate_en = d[ZGATE_BIT]; // RL8
            r.gain_code = d[GAIN_MSB:0]; // RL5 RL9
        end
        if (sel[1])
        begin
            r.silence = d[SILENCE_BIT]; // RL7
        end
        return r;
    endfunction : write_phones

    function automatic logic [DATA_W-1:0] read_phones(
        input phones_setting_t s
    );
        logic [DATA_W-1:0] r;
        r = '0;
        r[SILENCE_BIT] = s.silence;
        r[ZGATE_BIT] = s.zero_gate_en;
        r[GAIN_MSB:0] = s.gain_code;
        // Commit bit is a strobe and always reads zero
        r[COMMIT_BIT] = 1'b0; // RL12
        return r;
    endfunction : read_phones

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.ack = access;
        nxt_state.commit = 1'b0;
        nxt_state.rdata = '0;
        if (wr)
        begin
            unique case (idx)
                IDX_RSPK_ATTEN:
                begin
                    if (sel_i[0])
                    begin
                        nxt_state.atten = dat_i[ATTEN_MSB:0]; // RL1 RL2
                    end
                end
                IDX_PHONES_LEFT:
                begin
                    nxt_state.left = write_phones(state_ff.left, dat_i, sel_i);
                end
                IDX_PHONES_RIGHT:
                begin
                    nxt_state.right = write_phones(state_ff.right, dat_i,
                        sel_i);
                end
                IDX_TIMEOUT_CTRL:
                begin
                    if (sel_i[0])
                    begin
                        nxt_state.timeout_en = dat_i[TIMEOUT_EN_BIT]; // RL4
                    end
                end
                default:
                begin
                    nxt_state.timeout_en = state_ff.timeout_en;
                end
            endcase
            // Either side's commit bit commits both gains; each moves when its own gate allows
            if (sel_i[0] && dat_i[COMMIT_BIT] &&
                (idx == IDX_PHONES_LEFT || idx == IDX_PHONES_RIGHT)) // RL6
            begin
                nxt_state.commit = 1'b1; // RL12
            end
        end
        else if (access)
        begin
            unique case (idx)
                IDX_RSPK_ATTEN:
                begin
                    nxt_state.rdata[ATTEN_MSB:0] = state_ff.atten;
                end
                IDX_PHONES_LEFT:
                begin
                    nxt_state.rdata = read_phones(state_ff.left);
                end
                IDX_PHONES_RIGHT:
                begin
                    nxt_state.rdata = read_phones(state_ff.right);
                end
                IDX_TIMEOUT_CTRL:
                begin
                    nxt_state.rdata[TIMEOUT_EN_BIT] = state_ff.timeout_en;
                end
                IDX_GAIN_STATUS:
                begin
                    nxt_state.rdata[GAIN_MSB:0] = active[SIDE_LEFT];
                    nxt_state.rdata[STAT_RIGHT_LSB+GAIN_MSB:STAT_RIGHT_LSB] =
                        active[SIDE_RIGHT];
                    nxt_state.rdata[STAT_LEFT_PEND_BIT] = pending[SIDE_LEFT];
                    nxt_state.rdata[STAT_RIGHT_PEND_BIT] =
                        pending[SIDE_RIGHT];
                end
                default:
                begin
                    // Unmapped reads answer with zero
                    nxt_state.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= '0;
            state_ff.atten <= RSPK_ATTEN_RESET; // RL2
            state_ff.left <= PHONES_RESET; // RL7 RL8 RL10
            state_ff.right <= PHONES_RESET; // RL10
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign cfg[SIDE_LEFT] = state_ff.left;
    assign cfg[SIDE_RIGHT] = state_ff.right;
    assign sign_in[SIDE_LEFT] = left_sign_i;
    assign sign_in[SIDE_RIGHT] = right_sign_i;

    // Each side has its own gate, so one slow channel never holds the other
    generate
        for (genvar s = 0; s < SIDES; s++)
        begin : g_side
            zero_gate #(
                .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
            ) u_gate (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .commit_i(state_ff.commit), // RL6
                .staged_i(cfg[s].gain_code),
                .gate_en_i(cfg[s].zero_gate_en), // RL11
                .timeout_en_i(state_ff.timeout_en),
                .sign_i(sign_in[s]),
                .pending_o(pending[s]),
                .active_o(active[s])
            );
        end
    endgenerate

    assign dat_o = state_ff.rdata;
    assign ack_o = state_ff.ack;
    assign rspk_atten_o = state_ff.atten;
    assign phones_left_o = {state_ff.left.silence, pending[SIDE_LEFT],
        active[SIDE_LEFT]};
    assign phones_right_o = {state_ff.right.silence, pending[SIDE_RIGHT],
        active[SIDE_RIGHT]};
endmodule : output_volume_control_regs
`default_nettype wire

//--- dv/ovc_props.sv
`timescale 1ns/1ns
`default_nettype none
module ovc_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ovc_pkg::ADR_W-1:0] adr_i,
    input wire logic [ovc_pkg::DATA_W-1:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic [ovc_pkg::DATA_W-1:0] dat_o,
    input wire logic ack_o,
    input wire ovc_pkg::rspk_atten_t rspk_atten_o,
    input wire ovc_pkg::phones_output_t phones_left_o,
    input wire ovc_pkg::phones_output_t phones_right_o
);
    import ovc_pkg::*;
    logic req;
    logic wr_l;
    logic commit;
    assign req = cyc_i && stb_i && !ack_o;
    assign wr_l = req && we_i && adr_i[9:2] == IDX_PHONES_LEFT;
    // Either headphone register carries the commit strobe
    assign commit = req && we_i && sel_i[0] && dat_i[COMMIT_BIT]
        && (adr_i[9:2] == IDX_PHONES_LEFT || adr_i[9:2] == IDX_PHONES_RIGHT);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_req;
        req |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("ack not a single pulse after request");
    property p_dat_idle;
        !ack_o |-> dat_o == '0;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    property p_atten;
        req && we_i && sel_i[0] && adr_i[9:2] == IDX_RSPK_ATTEN
            |=> rspk_atten_o == $past(dat_i[3:0]);
    endproperty
    a_atten: assert property (p_atten)
        else $error("attenuation output wrong");
    property p_sil;
        wr_l && sel_i[1] |=> phones_left_o.silence == $past(dat_i[8]);
    endproperty
    a_sil: assert property (p_sil)
        else $error("silence not following write");
    property p_indep;
        wr_l |=> $stable(phones_right_o.silence) && $stable(rspk_atten_o);
    endproperty
    a_indep: assert property (p_indep)
        else $error("left write disturbed other output");
    property p_stage;
        !$stable(phones_left_o.active_gain)
            |-> $past(phones_left_o.pending) || $past(commit, 2);
    endproperty
    a_stage: assert property (p_stage)
        else $error("gain moved without commit");
    property p_pend_rise;
        $rose(phones_left_o.pending) |-> $past(commit, 2);
    endproperty
    a_pend_rise: assert property (p_pend_rise)
        else $error("pending without commit");
    property p_rst_gain;
        $past(rst_i) |-> phones_left_o.active_gain == 6'h2D
            && phones_right_o.active_gain == 6'h2D;
    endproperty
    a_rst_gain: assert property (p_rst_gain)
        else $error("gain reset value wrong");
endmodule : ovc_props
bind output_volume_control_regs ovc_props chk_u (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
    .ack_o(ack_o), .rspk_atten_o(rspk_atten_o),
    .phones_left_o(phones_left_o), .phones_right_o(phones_right_o));
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ovc_pkg::*;
    localparam int TO = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [ADR_W-1:0] adr_i = '0;
    logic [DATA_W-1:0] dat_i = '0;
    logic [3:0] sel_i = 4'hF;
    logic left_sign_i = 1'b0;
    logic right_sign_i = 1'b0;
    logic [DATA_W-1:0] dat_o;
    logic ack_o;
    rspk_atten_t rspk_atten_o;
    phones_output_t phones_left_o;
    phones_output_t phones_right_o;
    int bad_count = 0;
    int n_compared = 0;
    logic [31:0] q;
    always #10 clk_i = ~clk_i;
    output_volume_control_regs #(.TIMEOUT_CYCLES(TO)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
        .ack_o(ack_o), .left_sign_i(left_sign_i),
        .right_sign_i(right_sign_i), .rspk_atten_o(rspk_atten_o),
        .phones_left_o(phones_left_o), .phones_right_o(phones_right_o));
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] g, e, input string m);
        n_compared++;
        if (g !== e)
        begin
            $display("CHECK FAILED at %0t: %s", $time, m);
            bad_count++;
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk({31'h0, ack_o}, 32'h1, "bus ack timeout");
        if (ack_o !== 1'b1)
            report_and_stop;
    endtask : xfer
    task automatic wait_clear(input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (phones_left_o.pending !== 1'b0 && n < lim);
        chk({31'h0, phones_left_o.pending}, 32'h0, "still pending");
        if (phones_left_o.pending !== 1'b0)
            report_and_stop;
    endtask : wait_clear
    // Commit lands one edge after the write edge
    task automatic settle;
        repeat (2) @(posedge clk_i);
    endtask : settle
    task automatic t_reset;
        xfer(1'b0, IDX_RSPK_ATTEN, 32'h0);
        chk(q, 32'h0, "atten reset");
        xfer(1'b0, IDX_PHONES_LEFT, 32'h0);
        chk(q, 32'h2D, "left reset");
        xfer(1'b0, IDX_PHONES_RIGHT, 32'h0);
        chk(q, 32'h2D, "right reset");
        chk({24'h0, phones_right_o}, 32'h2D, "right out reset");
        $display("test reset done");
    endtask : t_reset
    task automatic t_atten;
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, IDX_RSPK_ATTEN, 32'h1 << i);
            chk({28'h0, rspk_atten_o}, 32'h1 << i, "atten out");
            xfer(1'b0, IDX_RSPK_ATTEN, 32'h0);
            chk(q, 32'h1 << i, "atten read");
        end
        $display("test atten done");
    endtask : t_atten
    task automatic t_stage;
        xfer(1'b1, IDX_PHONES_LEFT, 32'h000);
        xfer(1'b1, IDX_PHONES_RIGHT, 32'h03F);
        settle;
        chk({26'h0, phones_left_o.active_gain}, 32'h2D, "staged");
        xfer(1'b1, IDX_PHONES_LEFT, 32'h080);
        settle;
        chk({26'h0, phones_left_o.active_gain}, 32'h0, "left");
        chk({26'h0, phones_right_o.active_gain}, 32'h3F, "right");
        xfer(1'b0, IDX_PHONES_LEFT, 32'h0);
        chk(q, 32'h0, "commit bit read");
        xfer(1'b1, IDX_PHONES_RIGHT, 32'h039);
        settle;
        chk({26'h0, phones_right_o.active_gain}, 32'h3F, "no commit");
        $display("test stage done");
    endtask : t_stage
    task automatic t_mute;
        xfer(1'b1, IDX_PHONES_LEFT, 32'h100);
        chk({31'h0, phones_left_o.silence}, 32'h1, "left mute");
        chk({31'h0, phones_right_o.silence}, 32'h0, "right mute");
        sel_i <= 4'h2;
        xfer(1'b1, IDX_PHONES_LEFT, 32'h0FF);
        sel_i <= 4'hF;
        chk({31'h0, phones_left_o.silence}, 32'h0, "unmute");
        xfer(1'b0, IDX_PHONES_LEFT, 32'h0);
        chk(q, 32'h0, "lane 0 untouched");
        chk({26'h0, phones_left_o.active_gain}, 32'h0, "lane commit");
        $display("test mute done");
    endtask : t_mute
    task automatic t_zgate;
        xfer(1'b1, IDX_PHONES_LEFT, 32'h0D0);
        settle;
        chk({24'h0, phones_left_o}, 32'h40, "held");
        chk({26'h0, phones_right_o.active_gain}, 32'h39, "ungated");
        repeat (TO + 10) @(posedge clk_i);
        chk({31'h0, phones_left_o.pending}, 32'h1, "no timeout");
        left_sign_i <= 1'b1;
        wait_clear(10);
        chk({26'h0, phones_left_o.active_gain}, 32'h10, "crossed");
        xfer(1'b1, IDX_TIMEOUT_CTRL, 32'h1);
        xfer(1'b1, IDX_PHONES_LEFT, 32'h0C5);
        settle;
        repeat (TO - 2) @(posedge clk_i);
        chk({31'h0, phones_left_o.pending}, 32'h1, "early");
        wait_clear(1);
        chk({26'h0, phones_left_o.active_gain}, 32'h5, "timeout");
        xfer(1'b0, IDX_TIMEOUT_CTRL, 32'h0);
        chk(q, 32'h1, "timeout enable read");
        xfer(1'b0, IDX_GAIN_STATUS, 32'h0);
        chk(q, 32'h0000_3905, "gain status");
        xfer(1'b0, 8'h38, 32'h0);
        chk(q, 32'h0, "unmapped read");
        $display("test zero gate done");
    endtask : t_zgate
    task automatic t_right;
        xfer(1'b1, IDX_PHONES_RIGHT, 32'h1E0);
        right_sign_i <= 1'b1;
        settle;
        chk({24'h0, phones_right_o}, 32'hF9, "right held");
        settle;
        chk({24'h0, phones_right_o}, 32'hA0, "right crossed");
        $display("test right gate done");
    endtask : t_right
    task automatic t_rerst;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
    endtask : t_rerst
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_atten;
        t_stage;
        t_mute;
        t_zgate;
        t_right;
        t_rerst;
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
